// *** rtl/msc_cfg.svh ***
// Purpose: Constants for the motion settle and status control block
// Assumes: 25 MHz system clock
// Notes:   Offsets are word addresses on the register port
`ifndef MSC_CFG_SVH
`define MSC_CFG_SVH
`define MSC_ADDR_SETTLE     8'h49
`define MSC_ADDR_MOVING     8'h4A
`define MSC_ADDR_MAKEUP     8'hA0
`define MSC_ADDR_NUMERIC    8'hA1
`define MSC_ADDR_HOLD       8'hA2
`define MSC_SETTLE_RESET    16'h01F4
`define MSC_DELAY_MAX       17'h0FFFF
`define MSC_ERR_ILLEGAL     8'h15
`define MSC_ERR_NONE        8'h00
`define MSC_CLK_HZ          25000000
`define MSC_TICK_US         1000
`define MSC_TICK_CYCLES     ((`MSC_CLK_HZ / 1000000) * `MSC_TICK_US)
`define MSC_OUT_TYPE_MOVING 5'h11
`define MSC_OUT_TYPE_ATTN   5'h1D
`define MSC_ATTN_MOVING_BIT 14
`define MSC_LAG_LIMIT       16'h0119
`define MSC_SYS_SPEED       32'h00271000
`define MSC_NUM_OUTPUTS     3
`endif

// *** rtl/msc_pkg.sv ***
// Purpose: Types for the motion settle and status control block
// Assumes: Nothing beyond the cfg header
// Notes:   Types only
package msc_pkg;
    typedef enum logic [1:0] {
        MSC_KIND_ABS,
        MSC_KIND_REL,
        MSC_KIND_SLEW
    } msc_kind_t;
    typedef enum logic [1:0] {
        MSC_MU_FREE,
        MSC_MU_RATE,
        MSC_MU_SYS,
        MSC_MU_RSVD
    } msc_mu_t;
    typedef enum logic [1:0] {
        MSC_ST_IDLE,
        MSC_ST_MOVE,
        MSC_ST_DELAY,
        MSC_ST_HOLD
    } msc_state_t;
endpackage

// *** rtl/msc_tick.sv ***
// Purpose: Millisecond tick from the system clock
// Assumes: Clock enable freezes the divider
// Notes:   One-cycle pulse every tick period
`timescale 1ns/1ps
`include "msc_cfg.svh"
module msc_tick (
    // Clock and reset
    input  wire logic clk_sys,
    input  wire logic rst_b,
    input  wire logic clk_en,
    // Tick out
    output logic      tick_ms
);
    logic [14:0] cnt_q;
    logic [14:0] cnt_d;
    logic        tick_q;
    logic        tick_d;

    always_comb begin
        cnt_d  = cnt_q;
        tick_d = 1'b0;
        if (cnt_q == 15'(`MSC_TICK_CYCLES - 1)) begin
            cnt_d  = 15'h0000;
            tick_d = 1'b1;
        end else begin
            cnt_d = cnt_q + 15'h0001;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            cnt_q  <= 15'h0000;
            tick_q <= 1'b0;
        end else if (clk_en) begin
            cnt_q  <= cnt_d;
            tick_q <= tick_d;
        end
    end

    assign tick_ms = tick_q & clk_en;
endmodule // msc_tick

// *** rtl/msc_ctrl.sv ***
// Purpose: Settling delay, moving flag, make-up mode, numeric entry
// Assumes: Register port and motion events synchronous to clk_sys
// Notes:   Hold delay register lives here so the sum can be checked
`timescale 1ns/1ps
`include "msc_cfg.svh"

//////////////////////////////////////////////////////////////////////////////
module msc_ctrl (
    // Clock and reset
    input  wire logic                 clk_sys,
    input  wire logic                 rst_b,
    input  wire logic                 clk_en,
    // Register port
    input  wire logic                 reg_wr,
    input  wire logic                 reg_rd,
    input  wire logic [7:0]           reg_addr,
    input  wire logic [15:0]          reg_wdata,
    output logic      [15:0]          reg_rdata,
    output logic      [7:0]           reg_err,
    output logic                      reg_err_valid,
    // Motion commands from the parser
    input  wire logic                 cmd_move,
    input  wire logic [1:0]           cmd_kind,
    input  wire logic                 cmd_numeric,
    input  wire logic [31:0]          cmd_value,
    // Trajectory interface
    output logic                      move_start,
    output logic      [1:0]           move_kind,
    output logic      [31:0]          move_target,
    input  wire logic                 motion_busy,
    // Current control
    output logic                      hold_current_sel,
    // Make-up
    input  wire logic [15:0]          lag_lead_mag,
    input  wire logic [1:0]           closed_loop_select,
    input  wire logic                 bridge_enable,
    input  wire logic [31:0]          makeup_rate,
    output logic                      makeup_enable,
    output logic                      makeup_paced,
    output logic      [31:0]          makeup_speed,
    // Outputs and attention
    input  wire logic [15:0]          attention_mask,
    input  wire logic [14:0]          output_type,
    output logic      [2:0]           output_moving,
    output logic                      attention_moving,
    output logic                      axis_moving_flag
);
    //////////////////////////////////////////////////////////////////////////
    // Tick
    logic tick_ms;

    msc_tick u_tick (
        .clk_sys (clk_sys),
        .rst_b   (rst_b),
        .clk_en  (clk_en),
        .tick_ms (tick_ms)
    );

    //////////////////////////////////////////////////////////////////////////
    // Registers
    logic [15:0] settle_q;
    logic [15:0] settle_d;
    logic [15:0] hold_q;
    logic [15:0] hold_d;
    logic [1:0]  makeup_q;
    logic [1:0]  makeup_d;
    logic        numeric_q;
    logic        numeric_d;
    logic [15:0] rdata_q;
    logic [15:0] rdata_d;
    logic [7:0]  err_q;
    logic [7:0]  err_d;
    logic        errv_q;
    logic        errv_d;
    logic        bridge_q;
    logic        bridge_d;
    logic        moving_now;
    logic [16:0] sum_settle;
    logic [16:0] sum_hold;

    // Seventeen bits so the sum cannot wrap past the limit
    assign sum_settle = {1'b0, reg_wdata} + {1'b0, hold_q};
    assign sum_hold   = {1'b0, settle_q} + {1'b0, reg_wdata};

    always_comb begin
        settle_d  = settle_q;
        hold_d    = hold_q;
        makeup_d  = makeup_q;
        numeric_d = numeric_q;
        rdata_d   = rdata_q;
        err_d     = err_q;
        errv_d    = 1'b0;
        bridge_d  = bridge_enable;
        if (reg_wr) begin
            err_d = `MSC_ERR_NONE;
            if (reg_addr == `MSC_ADDR_SETTLE) begin
                if (sum_settle > `MSC_DELAY_MAX) begin
                    err_d  = `MSC_ERR_ILLEGAL;
                    errv_d = 1'b1;
                end else begin
                    settle_d = reg_wdata;
                end
            end else if (reg_addr == `MSC_ADDR_HOLD) begin
                if (sum_hold > `MSC_DELAY_MAX) begin
                    err_d  = `MSC_ERR_ILLEGAL;
                    errv_d = 1'b1;
                end else begin
                    hold_d = reg_wdata;
                end
            end else if (reg_addr == `MSC_ADDR_MAKEUP) begin
                // Values above 2 are refused like an over-range delay
                if (reg_wdata > 16'h0002) begin
                    err_d  = `MSC_ERR_ILLEGAL;
                    errv_d = 1'b1;
                end else begin
                    makeup_d = reg_wdata[1:0];
                end
            end else if (reg_addr == `MSC_ADDR_NUMERIC) begin
                numeric_d = reg_wdata[0];
            end
        end
        // Clear on falling bridge enable in closed loop; wins over a write
        if (bridge_q && !bridge_enable &&
            (closed_loop_select == 2'h1 || closed_loop_select == 2'h2)) begin
            makeup_d = 2'h0;
        end
        if (reg_rd) begin
            if (reg_addr == `MSC_ADDR_SETTLE) begin
                rdata_d = settle_q;
            end else if (reg_addr == `MSC_ADDR_MOVING) begin
                rdata_d = {15'h0000, moving_now};
            end else if (reg_addr == `MSC_ADDR_MAKEUP) begin
                rdata_d = {14'h0000, makeup_q};
            end else if (reg_addr == `MSC_ADDR_NUMERIC) begin
                rdata_d = {15'h0000, numeric_q};
            end else if (reg_addr == `MSC_ADDR_HOLD) begin
                rdata_d = hold_q;
            end else begin
                rdata_d = 16'h0000;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            settle_q  <= `MSC_SETTLE_RESET;
            hold_q    <= 16'h0000;
            makeup_q  <= 2'h0;
            numeric_q <= 1'b0;
            rdata_q   <= 16'h0000;
            err_q     <= `MSC_ERR_NONE;
            errv_q    <= 1'b0;
            bridge_q  <= 1'b0;
        end else if (clk_en) begin
            settle_q  <= settle_d;
            hold_q    <= hold_d;
            makeup_q  <= makeup_d;
            numeric_q <= numeric_d;
            rdata_q   <= rdata_d;
            err_q     <= err_d;
            errv_q    <= errv_d;
            bridge_q  <= bridge_d;
        end
    end

    assign reg_rdata     = rdata_q;
    assign reg_err       = err_q;
    assign reg_err_valid = errv_q;

    //////////////////////////////////////////////////////////////////////////
    // Move launch and kind store
    logic [1:0]  kind_q;
    logic [1:0]  kind_d;
    logic        start_q;
    logic        start_d;
    logic [31:0] target_q;
    logic [31:0] target_d;

    always_comb begin
        kind_d   = kind_q;
        start_d  = 1'b0;
        target_d = target_q;
        if (cmd_move) begin
            kind_d   = cmd_kind;
            start_d  = 1'b1;
            target_d = cmd_value;
        end else if (cmd_numeric && numeric_q) begin
            start_d  = 1'b1;
            target_d = cmd_value;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            kind_q   <= 2'h0;
            start_q  <= 1'b0;
            target_q <= 32'h00000000;
        end else if (clk_en) begin
            kind_q   <= kind_d;
            start_q  <= start_d;
            target_q <= target_d;
        end
    end

    assign move_start  = start_q & clk_en;
    assign move_kind   = kind_q;
    assign move_target = target_q;

    //////////////////////////////////////////////////////////////////////////
    // Settle and hold sequencer
    msc_pkg::msc_state_t st_q;
    msc_pkg::msc_state_t st_d;
    logic [15:0] dly_q;
    logic [15:0] dly_d;
    logic        hold_sel_q;
    logic        hold_sel_d;

    always_comb begin
        st_d       = st_q;
        dly_d      = dly_q;
        hold_sel_d = hold_sel_q;
        case (st_q)
            msc_pkg::MSC_ST_IDLE, msc_pkg::MSC_ST_HOLD: begin
                if (start_q || motion_busy) begin
                    st_d       = msc_pkg::MSC_ST_MOVE;
                    hold_sel_d = 1'b0;
                end
            end
            msc_pkg::MSC_ST_MOVE: begin
                if (!start_q && !motion_busy) begin
                    // Limit check on writes keeps this sum in 16 bits
                    dly_d = settle_q + hold_q;
                    if (settle_q == 16'h0000 && hold_q == 16'h0000) begin
                        st_d = msc_pkg::MSC_ST_IDLE;
                    end else begin
                        st_d = msc_pkg::MSC_ST_DELAY;
                    end
                end
            end
            msc_pkg::MSC_ST_DELAY: begin
                if (start_q || motion_busy) begin
                    st_d = msc_pkg::MSC_ST_MOVE;
                end else if (tick_ms) begin
                    dly_d = dly_q - 16'h0001;
                    if (dly_q == 16'h0001) begin
                        st_d       = msc_pkg::MSC_ST_HOLD;
                        hold_sel_d = 1'b1;
                    end
                end
            end
            default: begin
                st_d = msc_pkg::MSC_ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            st_q       <= msc_pkg::MSC_ST_IDLE;
            dly_q      <= 16'h0000;
            hold_sel_q <= 1'b0;
        end else if (clk_en) begin
            st_q       <= st_d;
            dly_q      <= dly_d;
            hold_sel_q <= hold_sel_d;
        end
    end

    // Delay phase counts as moving
    assign moving_now = (st_q == msc_pkg::MSC_ST_MOVE) ||
                        (st_q == msc_pkg::MSC_ST_DELAY);
    assign hold_current_sel = hold_sel_q;
    assign axis_moving_flag = moving_now;

    //////////////////////////////////////////////////////////////////////////
    // Output routing, five type bits per output
    genvar gi;
    generate
        for (gi = 0; gi < `MSC_NUM_OUTPUTS; gi = gi + 1) begin : g_out
            logic [4:0] otype;
            assign otype = output_type[gi*5 +: 5];
            assign output_moving[gi] = moving_now &&
                ((otype == `MSC_OUT_TYPE_MOVING) ||
                 (otype == `MSC_OUT_TYPE_ATTN &&
                  attention_mask[`MSC_ATTN_MOVING_BIT]));
        end
    endgenerate
    assign attention_moving = moving_now &&
        attention_mask[`MSC_ATTN_MOVING_BIT];

    //////////////////////////////////////////////////////////////////////////
    // Make-up control; steps may come during or after a move
    assign makeup_enable = (lag_lead_mag <= `MSC_LAG_LIMIT);
    assign makeup_paced  = (makeup_q != 2'h0);
    assign makeup_speed  =
        (makeup_q == 2'h1) ? makeup_rate :
        (makeup_q == 2'h2) ? `MSC_SYS_SPEED : 32'h00000000;
endmodule // msc_ctrl

// *** sim/msc_ctrl_assertions.sv ***
// Purpose: Port-level checks for the settle and status control block
// Assumes: One clk_sys domain, rst_b active low
// Notes:   Bound onto msc_ctrl below the module
`timescale 1ns/1ps
`include "msc_cfg.svh"
module msc_ctrl_chk (
    // Clock and reset
    input wire logic        clk_sys,
    input wire logic        rst_b,
    input wire logic        clk_en,
    // Register result
    input wire logic [7:0]  reg_err,
    input wire logic        reg_err_valid,
    // Moves
    input wire logic        cmd_move,
    input wire logic [1:0]  cmd_kind,
    input wire logic [31:0] cmd_value,
    input wire logic        move_start,
    input wire logic [1:0]  move_kind,
    input wire logic [31:0] move_target,
    input wire logic        motion_busy,
    input wire logic        hold_current_sel,
    input wire logic        axis_moving_flag,
    // Make-up
    input wire logic [15:0] lag_lead_mag,
    input wire logic [31:0] makeup_rate,
    input wire logic        makeup_enable,
    input wire logic        makeup_paced,
    input wire logic [31:0] makeup_speed,
    // Outputs and attention
    input wire logic [15:0] attention_mask,
    input wire logic [14:0] output_type,
    input wire logic [2:0]  output_moving,
    input wire logic        attention_moving
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_b);
    logic [2:0] route_exp;
    always_comb begin
        for (int i = 0; i < 3; i++) begin
            route_exp[i] = axis_moving_flag &&
                (output_type[5*i +: 5] == `MSC_OUT_TYPE_MOVING ||
                 (output_type[5*i +: 5] == `MSC_OUT_TYPE_ATTN &&
                  attention_mask[`MSC_ATTN_MOVING_BIT]));
        end
    end
    sequence s_cmd;
        cmd_move && clk_en;
    endsequence
    sequence s_launch;
        move_start ##1 axis_moving_flag;
    endsequence
    //////////////////////////////////////////////////////////////////////
    a_cmd_launch: assert property (s_cmd |=> s_launch)
        else $error("move command did not launch a flagged move");
    a_kind_stored: assert property (s_cmd |=>
        move_kind == $past(cmd_kind) && move_target == $past(cmd_value))
        else $error("move kind or target not stored");
    a_busy_moving: assert property (motion_busy |-> axis_moving_flag)
        else $error("moving flag low while stepping");
    a_hold_at_end: assert property ($rose(hold_current_sel) |->
        $fell(axis_moving_flag) && !motion_busy)
        else $error("hold current not at end of move");
    a_err_code: assert property (reg_err_valid |-> reg_err == 8'h15)
        else $error("rejected write without illegal code");
    a_makeup_window: assert property
        (makeup_enable == (lag_lead_mag <= `MSC_LAG_LIMIT))
        else $error("make-up enable outside lag window");
    a_paced_speed: assert property (makeup_paced |->
        makeup_speed == makeup_rate || makeup_speed == `MSC_SYS_SPEED)
        else $error("paced make-up speed wrong");
    a_free_speed: assert property (!makeup_paced |-> makeup_speed == 0)
        else $error("untimed make-up has a speed");
    a_out_route: assert property (output_moving == route_exp)
        else $error("moving flag routing to outputs wrong");
    a_attn_route: assert property (attention_moving ==
        (axis_moving_flag && attention_mask[`MSC_ATTN_MOVING_BIT]))
        else $error("attention routing wrong");
endmodule // msc_ctrl_chk
bind msc_ctrl msc_ctrl_chk u_chk (.clk_sys, .rst_b, .clk_en, .reg_err,
    .reg_err_valid, .cmd_move, .cmd_kind, .cmd_value, .move_start,
    .move_kind, .move_target, .motion_busy, .hold_current_sel,
    .axis_moving_flag, .lag_lead_mag, .makeup_rate, .makeup_enable,
    .makeup_paced, .makeup_speed, .attention_mask, .output_type,
    .output_moving, .attention_moving);

// *** sim/msc_traj_model.sv ***
// Purpose: Trajectory generator stand-in that steps for run_len cycles
// Assumes: move_start is a one-cycle pulse
// Notes:   Busy rises the cycle after the start pulse is seen
`timescale 1ns/1ps
module msc_traj_model (
    // Clock and reset
    input  wire logic        clk_sys,
    input  wire logic        rst_b,
    // Trajectory handshake
    input  wire logic        move_start,
    input  wire logic [15:0] run_len,
    output logic             motion_busy
);
    logic [15:0] left_q;
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            left_q <= 16'h0000;
        end else if (move_start) begin
            left_q <= run_len;
        end else if (left_q != 16'h0000) begin
            left_q <= left_q - 16'h0001;
        end
    end
    assign motion_busy = (left_q != 16'h0000);
endmodule // msc_traj_model

// *** sim/tb_motion_settle_status_control.sv ***
// Purpose: Register and move sequences against msc_ctrl
// Assumes: Inputs change 1 ns after the rising edge
// Notes:   Settle kept at 1 ms so the run stays short
`timescale 1ns/1ps
`include "msc_cfg.svh"
module tb_motion_settle_status_control;
    logic        clk_sys = 1'b0, rst_b = 1'b0, clk_en = 1'b1;
    logic        reg_wr = 1'b0, reg_rd = 1'b0, reg_err_valid;
    logic [7:0]  reg_addr = 8'h00, reg_err;
    logic [15:0] reg_wdata = 16'h0000, reg_rdata, lag_lead_mag = 16'h0000;
    logic        cmd_move = 1'b0, cmd_numeric = 1'b0, bridge_enable = 1'b1;
    logic [1:0]  cmd_kind = 2'h0, move_kind, closed_loop_select = 2'h1;
    logic [31:0] cmd_value = 32'h0, move_target, makeup_speed;
    logic [31:0] makeup_rate = 32'h00001234;
    logic        move_start, hold_current_sel, motion_busy;
    logic        makeup_enable, makeup_paced, attention_moving;
    logic        axis_moving_flag;
    logic [15:0] attention_mask = 16'h4000, run_len = 16'h0014;
    logic [14:0] output_type = 15'h03B1;
    logic [2:0]  output_moving;
    int          n_mismatch = 0, total_checks = 0, waited;
    always #20 clk_sys = ~clk_sys;
    msc_ctrl dut (.clk_sys, .rst_b, .clk_en, .reg_wr, .reg_rd, .reg_addr,
        .reg_wdata, .reg_rdata, .reg_err, .reg_err_valid, .cmd_move,
        .cmd_kind, .cmd_numeric, .cmd_value, .move_start, .move_kind,
        .move_target, .motion_busy, .hold_current_sel, .lag_lead_mag,
        .closed_loop_select, .bridge_enable, .makeup_rate, .makeup_enable,
        .makeup_paced, .makeup_speed, .attention_mask, .output_type,
        .output_moving, .attention_moving, .axis_moving_flag);
    msc_traj_model u_traj (.clk_sys, .rst_b, .move_start, .run_len,
        .motion_busy);
    //////////////////////////////////////////////////////////////////////
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic step();
        @(posedge clk_sys);
        #1;
    endtask
    task automatic reg_write(input logic [7:0] a, input logic [15:0] d,
                             input logic [7:0] e);
        step();
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        step();
        reg_wr = 1'b0;
        check(reg_err, e);
        check(reg_err_valid, e == 8'h15);
    endtask
    task automatic reg_read(input logic [7:0] a, input logic [15:0] e);
        step();
        reg_addr = a;
        reg_rd = 1'b1;
        step();
        reg_rd = 1'b0;
        check(reg_rdata, e);
    endtask
    task automatic move(input logic [1:0] k, input logic [31:0] v,
                        input logic numeric, input logic started);
        step();
        cmd_kind = k;
        cmd_value = v;
        cmd_numeric = numeric;
        cmd_move = !numeric;
        step();
        cmd_numeric = 1'b0;
        cmd_move = 1'b0;
        check(move_start, started);
        // The flag rises the cycle after the start pulse
        step();
        check(axis_moving_flag, started);
    endtask
    task automatic wait_idle(input int bound);
        waited = 0;
        while (axis_moving_flag !== 1'b0) begin
            if (waited == bound) begin
                n_mismatch++;
                $display("ERROR %0t: moving flag stuck high", $time);
                tally_and_finish();
            end
            step();
            waited++;
        end
    endtask
    //////////////////////////////////////////////////////////////////////
    initial begin
        repeat (10) @(posedge clk_sys);
        #1 rst_b = 1'b1;
        reg_read(`MSC_ADDR_SETTLE, 16'h01F4);
        reg_read(`MSC_ADDR_MAKEUP, 16'h0000);
        reg_read(`MSC_ADDR_NUMERIC, 16'h0000);
        reg_read(8'h10, 16'h0000);
        $display("test reset done");
        reg_write(`MSC_ADDR_SETTLE, 16'hFFFF, 8'h00);
        reg_write(`MSC_ADDR_HOLD, 16'h0001, 8'h15);
        reg_read(`MSC_ADDR_HOLD, 16'h0000);
        $display("test limit done");
        for (int m = 0; m < 3; m++) begin
            reg_write(`MSC_ADDR_MAKEUP, m[15:0], 8'h00);
            reg_read(`MSC_ADDR_MAKEUP, m[15:0]);
            check(makeup_speed, m == 1 ? makeup_rate :
                  m == 2 ? `MSC_SYS_SPEED : 32'h0);
            check(makeup_paced, m != 0);
        end
        reg_write(`MSC_ADDR_MAKEUP, 16'h0003, 8'h15);
        bridge_enable = 1'b0;
        reg_read(`MSC_ADDR_MAKEUP, 16'h0000);
        bridge_enable = 1'b1;
        lag_lead_mag = `MSC_LAG_LIMIT;
        step();
        check(makeup_enable, 1'b1);
        lag_lead_mag = `MSC_LAG_LIMIT + 16'h0001;
        step();
        check(makeup_enable, 1'b0);
        $display("test makeup done");
        // Encoder functions stay off, so a 1 ms settle is allowed
        reg_write(`MSC_ADDR_SETTLE, 16'h0001, 8'h00);
        move(2'h1, 32'h00000100, 1'b0, 1'b1);
        repeat (5) step();
        check(output_moving, 3'h3);
        check(attention_moving, 1'b1);
        reg_read(`MSC_ADDR_MOVING, 16'h0001);
        repeat (20) step();
        check(axis_moving_flag, 1'b1);
        check(hold_current_sel, 1'b0);
        wait_idle(26000);
        check(hold_current_sel, 1'b1);
        check(waited <= 25005, 1'b1);
        reg_read(`MSC_ADDR_MOVING, 16'h0000);
        $display("test settle done");
        reg_write(`MSC_ADDR_SETTLE, 16'h0000, 8'h00);
        for (int k = 0; k < 3; k++) begin
            move(k[1:0], 32'h00000040, 1'b0, 1'b1);
            check(move_kind, k[1:0]);
            wait_idle(40);
            check(hold_current_sel, 1'b0);
        end
        $display("test kinds done");
        move(2'h0, 32'h0000ABCD, 1'b1, 1'b0);
        reg_write(`MSC_ADDR_NUMERIC, 16'h0001, 8'h00);
        move(2'h0, 32'h0000ABCD, 1'b1, 1'b1);
        check(move_kind, 2'h2);
        check(move_target, 32'h0000ABCD);
        wait_idle(40);
        $display("test numeric done");
        // A write while the clock enable is low must leave no trace
        clk_en = 1'b0;
        reg_write(`MSC_ADDR_SETTLE, 16'h0007, 8'h00);
        clk_en = 1'b1;
        reg_read(`MSC_ADDR_SETTLE, 16'h0000);
        $display("test freeze done");
        tally_and_finish();
    end
endmodule // tb_motion_settle_status_control
